//--- rtl/rscc_pkg.sv
// Constants, types and carriers of the reset source combiner and cause status block.
// Assumes one 20 MHz system clock and an asynchronous active-low power-on reset as the root.
//
// Overview of operation
// - Any active reset source drives the single master reset output.
// - Every reset sets the cause flag naming its own reset type.
// - Power-on clears the cause register except brown-out and power-on flags, which set.
// - Software may write any cause bit either way; writes never start a reset.
// - Supply events during low-power operation set flags in the supply status register.
// - Bit 12 enables retention regulator in sleep unless low-power fuse reads one.
// - Bit 10 sets on power-save argument zero while deep sleep enable is set.
// - Bit 5 enables watchdog by software; watchdog fuse at one forces it on.
// - Bit 4 sets on watchdog timeout; watchdog clear, power-save or power-on clear it.
// - Bit 3 sets on power-save argument zero, marking sleep entry.
// - Bit 2 sets on power-save argument one, marking idle entry.
// - Bit 1 sets on brown-out and power-on; bit 0 only on power-on.
// - Supply bits 3:0 set by hardware, cleared by software; upper bits read zero.
// - Supply bit 3 flags main brown-out, bit 2 main power-on.
// - Supply bit 1 flags backup domain power-on, bit 0 power-on exit on battery.
// - Other registers reset alike for every reset type; exceptions handled separately.
// - Oscillator reset value follows reset type; calibration and flash reset only at power-on.
// - Master reset releases after its delay; code runs once clock is also ready.
// - Fail-safe clock monitor starts after master reset release plus its own delay.
// - Power-on delay of 10 us precedes the internal state reset time.
// - Internal state reset time of 2 us is the only delay for most resets.
// - Oscillator start-up timer counts 1024 oscillator periods in ten bits.

package rscc_pkg;

  // Timing figures and the cycle counts derived from them
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned POR_DELAY_NS = 10000;
  localparam int unsigned STATE_RESET_NS = 2000;
  localparam int unsigned POR_CYCLES = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_CYCLES = (STATE_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REG_WAKE_CYCLES_DEF = 20;
  localparam int unsigned FAILSAFE_CLOCK_MONITOR_DELAY_CYCLES_DEF = 8;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned OST_W = 10;
  localparam logic [OST_W-1:0] OST_LAST = 10'h3FF;

  typedef logic [CNT_W-1:0] rscc_cnt_t;

  // Register map, word index on the register port
  localparam logic [1:0] ADDR_CAUSE = 2'h0;
  localparam logic [1:0] ADDR_SUPPLY = 2'h1;

  // Cause register fields
  localparam int unsigned BIT_TRAP = 15;
  localparam int unsigned BIT_BADOP = 14;
  localparam int unsigned BIT_RETENTION_ENABLE = 12;
  localparam int unsigned BIT_DEEP_SLEEP_FLAG = 10;
  localparam int unsigned BIT_CM = 9;
  localparam int unsigned BIT_FLASHPWR = 8;
  localparam int unsigned BIT_PIN = 7;
  localparam int unsigned BIT_SWR = 6;
  localparam int unsigned BIT_SOFT_WATCHDOG_ENABLE = 5;
  localparam int unsigned BIT_WATCHDOG_TIMEOUT_FLAG = 4;
  localparam int unsigned BIT_SLEEP = 3;
  localparam int unsigned BIT_IDLE = 2;
  localparam int unsigned BIT_BOR = 1;
  localparam int unsigned BIT_POR = 0;
  localparam logic [15:0] CAUSE_MASK = 16'hD7FF;
  localparam logic [15:0] CAUSE_POR_VALUE = 16'h0003;

  // Supply status fields
  localparam int unsigned SUP_MAIN_BO = 3;
  localparam int unsigned SUP_MAIN_PO = 2;
  localparam int unsigned SUP_BACKUP_PO = 1;
  localparam int unsigned SUP_BATT_EXIT = 0;
  localparam logic [3:0] SUPPLY_POR_VALUE = 4'hE;

  // Synchroniser lanes for inputs from outside the clock domain
  localparam int unsigned SY_BROWN = 0;
  localparam int unsigned SY_PIN_N = 1;
  localparam int unsigned SY_MAIN_BO = 2;
  localparam int unsigned SY_MAIN_PO = 3;
  localparam int unsigned SY_BACKUP_PO = 4;
  localparam int unsigned SY_BATT_EXIT = 5;
  localparam int unsigned SY_OSC = 6;
  localparam int unsigned SY_PLL = 7;
  localparam int unsigned SYNC_W = 8;
  localparam logic [SYNC_W-1:0] SYNC_RST = 8'h02;

  typedef enum logic [1:0] {
    ST_POR = 2'b00,
    ST_STARTUP = 2'b01,
    ST_RST = 2'b10,
    ST_RUN = 2'b11
  } rscc_seq_t;

  // Reset requests from logic on the system clock
  typedef struct packed {
    logic trap_conflict;
    logic illegal_opcode;
    logic uninit_register_reset;
    logic config_mismatch;
    logic reset_instruction;
    logic watchdog_timeout;
  } rscc_src_t;

  // Whole state of the block
  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    rscc_seq_t seq;
    rscc_cnt_t cnt;
    logic [15:0] cause;
    logic [3:0] supply;
    logic [15:0] rdata;
    logic osc_prev;
    logic [OST_W-1:0] ost_cnt;
    logic ost_done;
    rscc_cnt_t failsafe_clock_monitor_cnt;
    logic failsafe_clock_monitor_en;
    rscc_cnt_t wake_cnt;
    logic wake_hold;
    logic master;
    logic run_en;
    logic wdt_en;
    logic ret_en;
    logic flash_pwr;
    logic osc_use_fuse;
    logic por_rst;
  } rscc_state_t;

endpackage

//--- rtl/rscc_top.sv
// Reset source combiner with reset cause and supply status registers.
// Assumes CPU-side requests are synchronous pulses or levels on i_clock; supply monitors,
// the reset pin, the oscillator clock and PLL lock arrive asynchronously.
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module rscc_top #(
  parameter int unsigned REG_WAKE_CYCLES = rscc_pkg::REG_WAKE_CYCLES_DEF,
  parameter int unsigned FAILSAFE_CLOCK_MONITOR_DELAY_CYCLES = rscc_pkg::FAILSAFE_CLOCK_MONITOR_DELAY_CYCLES_DEF
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  // Register port
  input wire logic [1:0] i_addr,
  input wire logic [15:0] i_write_data,
  input wire logic i_write_strobe,
  input wire logic i_read_strobe,
  output logic [15:0] o_read_data,
  // Synchronous reset requests and instruction events
  input wire rscc_pkg::rscc_src_t i_src,
  input wire logic i_watchdog_clear_instr,
  input wire logic i_power_save_instr,
  input wire logic i_power_save_arg,
  input wire logic i_deep_sleep_enable,
  input wire logic i_sleep_exit,
  // Static fuses
  input wire logic i_low_power_fuse,
  input wire logic i_watchdog_fuse,
  // Asynchronous inputs
  input wire logic i_brown_out,
  input wire logic i_external_reset_pin_n,
  input wire logic i_main_supply_brownout,
  input wire logic i_main_supply_poweron,
  input wire logic i_backup_domain_poweron,
  input wire logic i_battery_exit,
  input wire logic i_osc_clock,
  input wire logic i_pll_locked,
  // Outputs
  output logic o_master_reset_out,
  output logic o_code_run_enable,
  output logic o_failsafe_monitor_enable,
  output logic o_watchdog_enable,
  output logic o_retention_enable,
  output logic o_flash_sleep_power,
  output logic o_regulator_wake_hold,
  output logic o_osc_reset_from_fuse,
  output logic o_poweron_reset
);

  localparam rscc_pkg::rscc_cnt_t POR_LAST = rscc_pkg::rscc_cnt_t'(rscc_pkg::POR_CYCLES - 1);
  localparam rscc_pkg::rscc_cnt_t RST_LAST = rscc_pkg::rscc_cnt_t'(rscc_pkg::RST_CYCLES - 1);
  localparam rscc_pkg::rscc_cnt_t WAKE_LAST = rscc_pkg::rscc_cnt_t'(REG_WAKE_CYCLES - 1);
  // The count starts on the release edge itself, so the last value equals the delay
  localparam rscc_pkg::rscc_cnt_t FAILSAFE_CLOCK_MONITOR_LAST = rscc_pkg::rscc_cnt_t'(FAILSAFE_CLOCK_MONITOR_DELAY_CYCLES);
  localparam rscc_pkg::rscc_state_t STATE_RESET = '{
    sync1: rscc_pkg::SYNC_RST,
    sync2: rscc_pkg::SYNC_RST,
    seq: rscc_pkg::ST_POR,
    cnt: '0,
    cause: rscc_pkg::CAUSE_POR_VALUE,
    supply: rscc_pkg::SUPPLY_POR_VALUE,
    rdata: 16'h0000,
    osc_prev: 1'b0,
    ost_cnt: '0,
    ost_done: 1'b0,
    failsafe_clock_monitor_cnt: '0,
    failsafe_clock_monitor_en: 1'b0,
    wake_cnt: '0,
    wake_hold: 1'b0,
    master: 1'b1,
    run_en: 1'b0,
    wdt_en: 1'b1,
    ret_en: 1'b0,
    flash_pwr: 1'b0,
    osc_use_fuse: 1'b1,
    por_rst: 1'b1
  };

  rscc_pkg::rscc_state_t q;
  rscc_pkg::rscc_state_t n;

  // Synchronised views of brown-out and reset pin, taken only from the second stage, and the request and write decodes
  logic brown_s;
  logic pin_s;
  logic cpu_src;
  logic any_src;
  logic cause_wr;
  logic supply_wr;

  assign brown_s = q.sync2[rscc_pkg::SY_BROWN];
  assign pin_s = ~q.sync2[rscc_pkg::SY_PIN_N];
  assign cpu_src = |i_src;
  assign any_src = cpu_src | brown_s | pin_s;
  assign cause_wr = i_write_strobe && (i_addr == rscc_pkg::ADDR_CAUSE);
  assign supply_wr = i_write_strobe && (i_addr == rscc_pkg::ADDR_SUPPLY);

  // Next-state logic for the whole block
  always_comb begin
    logic [15:0] cset;
    logic [15:0] cclr;
    logic [15:0] cbase;
    logic [3:0] sset;
    logic [3:0] sbase;
    cset = 16'h0000;
    cclr = 16'h0000;
    cbase = 16'h0000;
    sset = 4'h0;
    sbase = 4'h0;
    n = q;

    // Two-stage synchroniser for pins, supplies and the oscillator
    n.sync1 = {i_pll_locked, i_osc_clock, i_battery_exit, i_backup_domain_poweron,
               i_main_supply_poweron, i_main_supply_brownout, i_external_reset_pin_n,
               i_brown_out};
    n.sync2 = q.sync1;

    // Release sequencer; a source still active holds the start-up or state reset stage at the start of its delay
    case (q.seq)
      rscc_pkg::ST_POR: begin
        if (q.cnt >= POR_LAST) begin
          n.seq = rscc_pkg::ST_RST;
          n.cnt = '0;
        end else begin
          n.cnt = q.cnt + 1'b1;
        end
      end
      rscc_pkg::ST_STARTUP: begin
        if (any_src) begin
          n.cnt = '0;
        end else if (q.cnt >= WAKE_LAST) begin
          n.seq = rscc_pkg::ST_RST;
          n.cnt = '0;
        end else begin
          n.cnt = q.cnt + 1'b1;
        end
      end
      rscc_pkg::ST_RST: begin
        if (brown_s) begin
          // A brown-out inside another reset still needs the regulator start-up
          n.seq = rscc_pkg::ST_STARTUP;
          n.cnt = '0;
          n.osc_use_fuse = 1'b1;
        end else if (any_src) begin
          n.cnt = '0;
        end else if (q.cnt >= RST_LAST) begin
          n.seq = rscc_pkg::ST_RUN;
          n.cnt = '0;
        end else begin
          n.cnt = q.cnt + 1'b1;
        end
      end
      rscc_pkg::ST_RUN: begin
        // Brown-out also waits for the regulator before the state reset time
        if (brown_s) begin
          n.seq = rscc_pkg::ST_STARTUP;
          n.cnt = '0;
          n.osc_use_fuse = 1'b1;
        end else if (any_src) begin
          n.seq = rscc_pkg::ST_RST;
          n.cnt = '0;
          n.osc_use_fuse = 1'b0;
        end
      end
      default: begin
        n.seq = rscc_pkg::ST_POR;
        n.cnt = '0;
      end
    endcase
    n.master = (n.seq != rscc_pkg::ST_RUN);
    n.por_rst = (n.seq == rscc_pkg::ST_POR);

    // Cause flags: events set, instructions clear, software writes; set beats clear
    cset[rscc_pkg::BIT_TRAP] = i_src.trap_conflict;
    cset[rscc_pkg::BIT_BADOP] = i_src.illegal_opcode | i_src.uninit_register_reset;
    cset[rscc_pkg::BIT_CM] = i_src.config_mismatch;
    cset[rscc_pkg::BIT_PIN] = pin_s;
    cset[rscc_pkg::BIT_SWR] = i_src.reset_instruction;
    cset[rscc_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = i_src.watchdog_timeout;
    cset[rscc_pkg::BIT_SLEEP] = i_power_save_instr & ~i_power_save_arg;
    cset[rscc_pkg::BIT_IDLE] = i_power_save_instr & i_power_save_arg;
    cset[rscc_pkg::BIT_DEEP_SLEEP_FLAG] = i_power_save_instr & ~i_power_save_arg & i_deep_sleep_enable;
    cset[rscc_pkg::BIT_BOR] = brown_s;
    cclr[rscc_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = i_watchdog_clear_instr | i_power_save_instr;
    cbase = cause_wr ? i_write_data : q.cause;
    // Flags live outside the master reset, so they survive the reset they report
    n.cause = ((cbase & ~cclr) | cset) & rscc_pkg::CAUSE_MASK;

    // Supply status: hardware may only set, software may only clear by writing zero
    sset[rscc_pkg::SUP_MAIN_BO] = q.sync2[rscc_pkg::SY_MAIN_BO];
    sset[rscc_pkg::SUP_MAIN_PO] = q.sync2[rscc_pkg::SY_MAIN_PO];
    sset[rscc_pkg::SUP_BACKUP_PO] = q.sync2[rscc_pkg::SY_BACKUP_PO];
    sset[rscc_pkg::SUP_BATT_EXIT] = q.sync2[rscc_pkg::SY_BATT_EXIT];
    sbase = supply_wr ? (q.supply & i_write_data[3:0]) : q.supply;
    n.supply = sbase | sset;

    // Read data stands only in the cycle after the strobe
    n.rdata = 16'h0000;
    if (i_read_strobe) begin
      case (i_addr)
        rscc_pkg::ADDR_CAUSE: n.rdata = q.cause;
        rscc_pkg::ADDR_SUPPLY: n.rdata = {12'h000, q.supply};
        default: n.rdata = 16'h0000;
      endcase
    end

    // Control bits driven out to the watchdog, regulator and flash
    n.wdt_en = i_watchdog_fuse | q.cause[rscc_pkg::BIT_SOFT_WATCHDOG_ENABLE];
    n.ret_en = q.cause[rscc_pkg::BIT_RETENTION_ENABLE] & ~i_low_power_fuse;
    n.flash_pwr = q.cause[rscc_pkg::BIT_FLASHPWR];

    // Oscillator start-up timer counts rising edges of the synchronised oscillator;
    // it runs from power-on only, in parallel with the reset delays
    n.osc_prev = q.sync2[rscc_pkg::SY_OSC];
    if (!q.ost_done && q.sync2[rscc_pkg::SY_OSC] && !q.osc_prev) begin
      if (q.ost_cnt == rscc_pkg::OST_LAST) begin
        n.ost_done = 1'b1;
      end else begin
        n.ost_cnt = q.ost_cnt + 1'b1;
      end
    end
    n.run_en = ~n.master & n.ost_done & q.sync2[rscc_pkg::SY_PLL];

    // Fail-safe monitor waits its own delay after the master reset falls
    if (n.master) begin
      n.failsafe_clock_monitor_cnt = '0;
      n.failsafe_clock_monitor_en = 1'b0;
    end else if (!q.failsafe_clock_monitor_en) begin
      if (q.failsafe_clock_monitor_cnt >= FAILSAFE_CLOCK_MONITOR_LAST) begin
        n.failsafe_clock_monitor_en = 1'b1;
      end else begin
        n.failsafe_clock_monitor_cnt = q.failsafe_clock_monitor_cnt + 1'b1;
      end
    end

    // Regulator wake delay on sleep exit while flash bias power was in standby
    if (i_sleep_exit && !q.cause[rscc_pkg::BIT_FLASHPWR]) begin
      n.wake_hold = 1'b1;
      n.wake_cnt = '0;
    end else if (q.wake_hold) begin
      if (q.wake_cnt >= WAKE_LAST) begin
        n.wake_hold = 1'b0;
      end else begin
        n.wake_cnt = q.wake_cnt + 1'b1;
      end
    end
  end

  // Power-on is the root reset; only it restores calibration style state
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= STATE_RESET;
    end else begin
      q <= n;
    end
  end

  assign o_read_data = q.rdata;
  assign o_master_reset_out = q.master;
  assign o_code_run_enable = q.run_en;
  assign o_failsafe_monitor_enable = q.failsafe_clock_monitor_en;
  assign o_watchdog_enable = q.wdt_en;
  assign o_retention_enable = q.ret_en;
  assign o_flash_sleep_power = q.flash_pwr;
  assign o_regulator_wake_hold = q.wake_hold;
  assign o_osc_reset_from_fuse = q.osc_use_fuse;
  assign o_poweron_reset = q.por_rst;

  // Checks on the design's own behaviour
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_arst_n);

  sequence s_rst_done;
    (q.seq == rscc_pkg::ST_RST) && !any_src && (q.cnt == RST_LAST);
  endsequence

  sequence s_released;
    (q.seq == rscc_pkg::ST_RUN) && !o_master_reset_out;
  endsequence

  sequence s_por_done;
    (q.seq == rscc_pkg::ST_POR) && (q.cnt == POR_LAST);
  endsequence

  master_on_src_a: assert property (any_src |=> o_master_reset_out)
    else $error("reset source did not raise master reset");
  state_release_a: assert property (s_rst_done |=> s_released)
    else $error("master reset not released after state reset time");
  por_to_rst_a: assert property (s_por_done |=> (q.seq == rscc_pkg::ST_RST) && o_master_reset_out)
    else $error("power-on delay did not lead into state reset");
  wdt_flag_set_a: assert property (i_src.watchdog_timeout |=> q.cause[rscc_pkg::BIT_WATCHDOG_TIMEOUT_FLAG])
    else $error("watchdog timeout flag not set");
  wdt_flag_clear_a: assert property ((i_watchdog_clear_instr && !i_src.watchdog_timeout && !cause_wr)
    |=> !q.cause[rscc_pkg::BIT_WATCHDOG_TIMEOUT_FLAG])
    else $error("watchdog flag not cleared by clear instruction");
  sleep_idle_a: assert property (i_power_save_instr |=>
    (i_power_save_arg ? q.cause[rscc_pkg::BIT_IDLE] : q.cause[rscc_pkg::BIT_SLEEP]))
    else $error("power-save did not mark sleep or idle");
  deep_sleep_a: assert property ((i_power_save_instr && !i_power_save_arg && i_deep_sleep_enable)
    |=> q.cause[rscc_pkg::BIT_DEEP_SLEEP_FLAG] && q.cause[rscc_pkg::BIT_SLEEP])
    else $error("deep sleep flag not set");
  wdt_enable_a: assert property ((i_watchdog_fuse || q.cause[rscc_pkg::BIT_SOFT_WATCHDOG_ENABLE]) |=> o_watchdog_enable)
    else $error("watchdog enable not driven");
  retention_a: assert property (i_low_power_fuse |=> !o_retention_enable)
    else $error("retention enabled despite low-power fuse");
  write_no_reset_a: assert property ((cause_wr && !any_src && q.seq == rscc_pkg::ST_RUN)
    |=> !o_master_reset_out)
    else $error("cause register write caused a reset");
  supply_set_a: assert property (q.sync2[rscc_pkg::SY_MAIN_BO] |=> q.supply[rscc_pkg::SUP_MAIN_BO])
    else $error("main supply brown-out flag lost");
  failsafe_clock_monitor_gate_a: assert property (o_failsafe_monitor_enable |-> !o_master_reset_out
    && $past(!o_master_reset_out, 1))
    else $error("clock monitor active during master reset");
  run_gate_a: assert property (o_code_run_enable |-> !o_master_reset_out && q.ost_done)
    else $error("code enabled before reset release and clock ready");

  // Each reset source leaves its own cause flag
  trap_flag_a: assert property (i_src.trap_conflict |=> q.cause[rscc_pkg::BIT_TRAP])
    else $error("trap flag not set");

  badop_flag_a: assert property ((i_src.illegal_opcode || i_src.uninit_register_reset)
    |=> q.cause[rscc_pkg::BIT_BADOP])
    else $error("bad opcode flag not set");

  mismatch_flag_a: assert property (i_src.config_mismatch |=> q.cause[rscc_pkg::BIT_CM])
    else $error("mismatch flag not set");

  pin_flag_a: assert property (pin_s |=> q.cause[rscc_pkg::BIT_PIN])
    else $error("pin flag not set");

  brownout_flag_a: assert property (brown_s |=> q.cause[rscc_pkg::BIT_BOR])
    else $error("brown-out flag not set");

  // Trap and supply flags drop only where software writes zero
  trap_clear_a: assert property ((cause_wr && !i_write_data[rscc_pkg::BIT_TRAP]
    && !i_src.trap_conflict) |=> !q.cause[rscc_pkg::BIT_TRAP])
    else $error("trap flag not cleared");

  supply_sticky_a: assert property (!supply_wr
    |=> ((q.supply & $past(q.supply)) == $past(q.supply)))
    else $error("supply flag lost");

  supply_read_a: assert property ((i_read_strobe && (i_addr == rscc_pkg::ADDR_SUPPLY))
    |=> (o_read_data[15:4] == 12'h000))
    else $error("supply upper bits set");

  // Release delays and the oscillator choice per reset type
  state_hold_a: assert property ((q.seq == rscc_pkg::ST_RST) && (q.cnt < RST_LAST)
    |=> o_master_reset_out)
    else $error("early release");

  por_stage_a: assert property (o_poweron_reset |-> o_master_reset_out)
    else $error("power-on stage without reset");

  brown_osc_a: assert property (brown_s |=> o_osc_reset_from_fuse && o_master_reset_out)
    else $error("brown-out kept clock choice");

  other_osc_a: assert property ((q.seq == rscc_pkg::ST_RUN) && !brown_s && any_src
    |=> !o_osc_reset_from_fuse)
    else $error("fuse clock after other reset");

  run_pll_a: assert property (o_code_run_enable |-> $past(q.sync2[rscc_pkg::SY_PLL]))
    else $error("code enabled without lock");

  // Sleep exit and the clock monitor start
  wake_hold_a: assert property ((i_sleep_exit && !q.cause[rscc_pkg::BIT_FLASHPWR])
    |=> o_regulator_wake_hold)
    else $error("wake delay not started");

  sequence s_monitor_on;
    $rose(o_failsafe_monitor_enable);
  endsequence

  failsafe_clock_monitor_delay_a: assert property (s_monitor_on |-> !$past(o_master_reset_out, FAILSAFE_CLOCK_MONITOR_DELAY_CYCLES)
    && $past(o_master_reset_out, FAILSAFE_CLOCK_MONITOR_DELAY_CYCLES + 1))
    else $error("clock monitor delay wrong");

endmodule

`default_nettype wire

//--- verification/rscc_far_model.sv
// Far-side model: free-running oscillator waveform and a PLL lock level.
// Assumes the bench power-on reset; both outputs are asynchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none

module rscc_far_model #(
  parameter int unsigned OSC_HALF_NS = 300,
  parameter int unsigned LOCK_NS = 100000
) (
  input wire logic i_arst_n,
  output logic o_osc_clock,
  output logic o_pll_locked
);
  // Start values, so nothing unknown reaches the synchronisers
  initial begin
    o_osc_clock = 1'h0;
    o_pll_locked = 1'h0;
  end
  // Crystal runs free and slower than a quarter of the system clock, so no edge is lost
  always #(OSC_HALF_NS) o_osc_clock = ~o_osc_clock;
  // Lock is lost at power-on and regained after the lock time, apart from the reset delays
  always @(i_arst_n) begin
    o_pll_locked = 1'h0;
    if (i_arst_n === 1'h1) begin
      #(LOCK_NS);
      o_pll_locked = 1'h1;
    end
  end
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench of the reset source combiner and its cause and supply registers.
// Assumes the far-side model supplies oscillator and PLL lock; all else is driven here.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int unsigned WAKE = 6;
  localparam int unsigned FAILSAFE_CLOCK_MONITOR = 8;
  // Cause flag expected per source lane, lane 0 is watchdog, lane 5 trap conflict
  localparam logic [15:0] SRC_EXP [6] = '{16'h0010, 16'h0040, 16'h0200, 16'h4000, 16'h4000, 16'h8000};
  logic i_clock = 1'h0;
  logic i_arst_n = 1'h0;
  logic [1:0] i_addr = 2'h0;
  logic [15:0] i_write_data = 16'h0000;
  logic i_write_strobe = 1'h0;
  logic i_read_strobe = 1'h0;
  rscc_pkg::rscc_src_t i_src = '0;
  logic ps = 1'h0;
  logic ps_arg = 1'h0;
  logic deep = 1'h0;
  logic wclr = 1'h0;
  logic sexit = 1'h0;
  logic lp_fuse = 1'h0;
  logic wd_fuse = 1'h0;
  logic brown = 1'h0;
  logic pin_n = 1'h1;
  logic [3:0] sup = 4'h0;
  logic osc;
  logic pll;
  logic [15:0] o_read_data;
  logic master, run_en, failsafe_clock_monitor, wdt_en, ret_en, flash_pwr, wake_hold, osc_fuse, por;
  int failures = 0;
  int checks = 0;
  int cycles = 0;

  // System clock, 50 ns period
  always #25 i_clock = ~i_clock;

  rscc_far_model far_u (.i_arst_n(i_arst_n), .o_osc_clock(osc), .o_pll_locked(pll));

  rscc_top #(.REG_WAKE_CYCLES(WAKE), .FAILSAFE_CLOCK_MONITOR_DELAY_CYCLES(FAILSAFE_CLOCK_MONITOR)) dut_u (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_write_data(i_write_data),
    .i_write_strobe(i_write_strobe), .i_read_strobe(i_read_strobe), .o_read_data(o_read_data),
    .i_src(i_src), .i_watchdog_clear_instr(wclr), .i_power_save_instr(ps), .i_power_save_arg(ps_arg),
    .i_deep_sleep_enable(deep), .i_sleep_exit(sexit), .i_low_power_fuse(lp_fuse),
    .i_watchdog_fuse(wd_fuse), .i_brown_out(brown), .i_external_reset_pin_n(pin_n),
    .i_main_supply_brownout(sup[3]), .i_main_supply_poweron(sup[2]), .i_backup_domain_poweron(sup[1]),
    .i_battery_exit(sup[0]), .i_osc_clock(osc), .i_pll_locked(pll), .o_master_reset_out(master),
    .o_code_run_enable(run_en), .o_failsafe_monitor_enable(failsafe_clock_monitor), .o_watchdog_enable(wdt_en),
    .o_retention_enable(ret_en), .o_flash_sleep_power(flash_pwr), .o_regulator_wake_hold(wake_hold),
    .o_osc_reset_from_fuse(osc_fuse), .o_poweron_reset(por));

  task automatic wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic cb(input string n, input logic s, input logic e);
    chk(n, {15'h0000, s}, {15'h0000, e});
  endtask

  // Waits whole cycles, then steps past the edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_write_data <= d;
    i_write_strobe <= 1'h1;
    @(posedge i_clock);
    i_write_strobe <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are looked at there
  task automatic rd(input logic [1:0] a, input logic [15:0] e);
    @(posedge i_clock);
    i_addr <= a;
    i_read_strobe <= 1'h1;
    @(posedge i_clock);
    i_read_strobe <= 1'h0;
    #1;
    chk("read data", o_read_data, e);
  endtask

  // Bounded wait for the master reset to drop
  task automatic wait_rel(input int lim);
    for (int k = 0; k < lim && master !== 1'h0; k++) cyc(1);
  endtask

  task automatic src_case(input int i, input logic [15:0] e);
    wr(2'h0, 16'h0000);
    @(posedge i_clock);
    i_src <= rscc_pkg::rscc_src_t'(6'h01 << i);
    @(posedge i_clock);
    i_src <= '0;
    cyc(1);
    cb("master", master, 1'h1);
    cyc(28);
    cb("master", master, 1'h1);
    wait_rel(20);
    cb("master", master, 1'h0);
    cb("osc from fuse", osc_fuse, 1'h0);
    rd(2'h0, e);
  endtask

  // Brown-out when b is high, reset pin otherwise
  task automatic ext_case(input logic b, input logic [15:0] e);
    wr(2'h0, 16'h0000);
    @(posedge i_clock);
    brown <= b;
    pin_n <= b;
    cyc(4);
    cb("master", master, 1'h1);
    @(posedge i_clock);
    brown <= 1'h0;
    pin_n <= 1'h1;
    wait_rel(WAKE + 60);
    cb("master", master, 1'h0);
    cb("osc from fuse", osc_fuse, b);
    rd(2'h0, e);
  endtask

  // Power-save or watchdog-clear pulse with the timeout flag set beforehand
  task automatic ps_case(input logic a, input logic d, input logic c, input logic [15:0] e);
    wr(2'h0, 16'h0010);
    @(posedge i_clock);
    ps <= ~c;
    ps_arg <= a;
    deep <= d;
    wclr <= c;
    @(posedge i_clock);
    ps <= 1'h0;
    wclr <= 1'h0;
    rd(2'h0, e);
  endtask

  task automatic wake_case(input logic [15:0] c, input logic e);
    wr(2'h0, c);
    @(posedge i_clock);
    sexit <= 1'h1;
    @(posedge i_clock);
    sexit <= 1'h0;
    cyc(2);
    cb("wake hold", wake_hold, e);
    cyc(WAKE + 2);
    cb("wake hold", wake_hold, 1'h0);
  endtask

  // Cuts a hung run short
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      wrap_up;
    end
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge i_clock);
    cb("master", master, 1'h1);
    cb("poweron", por, 1'h1);
    i_arst_n <= 1'h1;
    rd(2'h0, 16'h0003);
    rd(2'h1, 16'h000E);
    cyc(170);
    cb("poweron", por, 1'h1);
    cyc(45);
    cb("poweron", por, 1'h0);
    cb("master", master, 1'h1);
    wait_rel(60);
    cb("master", master, 1'h0);
    cb("run", run_en, 1'h0);
    cb("monitor", failsafe_clock_monitor, 1'h0);
    cyc(FAILSAFE_CLOCK_MONITOR - 1);
    cb("monitor", failsafe_clock_monitor, 1'h0);
    cyc(1);
    cb("monitor", failsafe_clock_monitor, 1'h1);
    cyc(9800);
    cb("run", run_en, 1'h0);
    for (int k = 0; k < 3000 && run_en !== 1'h1; k++) cyc(1);
    cb("run", run_en, 1'h1);
    foreach (SRC_EXP[i]) src_case(i, SRC_EXP[i]);
    wr(2'h0, 16'hFFFF);
    cyc(2);
    cb("master", master, 1'h0);
    cb("watchdog", wdt_en, 1'h1);
    cb("retention", ret_en, 1'h1);
    cb("flash power", flash_pwr, 1'h1);
    rd(2'h0, 16'hD7FF);
    @(posedge i_clock);
    lp_fuse <= 1'h1;
    cyc(3);
    cb("retention", ret_en, 1'h0);
    wr(2'h0, 16'h0000);
    cyc(2);
    cb("watchdog", wdt_en, 1'h0);
    cb("flash power", flash_pwr, 1'h0);
    @(posedge i_clock);
    wd_fuse <= 1'h1;
    lp_fuse <= 1'h0;
    cyc(3);
    cb("watchdog", wdt_en, 1'h1);
    @(posedge i_clock);
    wd_fuse <= 1'h0;
    ps_case(1'h0, 1'h1, 1'h0, 16'h0408);
    ps_case(1'h0, 1'h0, 1'h0, 16'h0008);
    ps_case(1'h1, 1'h0, 1'h0, 16'h0004);
    ps_case(1'h0, 1'h0, 1'h1, 16'h0000);
    wake_case(16'h0000, 1'h1);
    wake_case(16'h0100, 1'h0);
    wr(2'h1, 16'h0000);
    wr(2'h1, 16'hFFFF);
    rd(2'h1, 16'h0000);
    for (int j = 0; j < 4; j++) begin
      @(posedge i_clock);
      sup <= 4'h1 << j;
      cyc(4);
      @(posedge i_clock);
      sup <= 4'h0;
      cyc(3);
      rd(2'h1, 16'h0001 << j);
      wr(2'h1, 16'hFFFF);
      rd(2'h1, 16'h0001 << j);
      wr(2'h1, 16'h0000);
    end
    wr(2'h2, 16'hFFFF);
    rd(2'h2, 16'h0000);
    rd(2'h3, 16'h0000);
    ext_case(1'h1, 16'h0002);
    ext_case(1'h0, 16'h0080);
    wr(2'h0, 16'hFFFF);
    @(posedge i_clock);
    i_arst_n <= 1'h0;
    cyc(2);
    cb("poweron", por, 1'h1);
    @(posedge i_clock);
    i_arst_n <= 1'h1;
    rd(2'h0, 16'h0003);
    rd(2'h1, 16'h000E);
    wrap_up;
  end
endmodule
`default_nettype wire
